//--- iau_pkg.sv
// Constants, types and field layout of the integer add instruction unit.
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
// Overview of operation
// - General add sums two operands at byte, word or long and writes destination.
// - Operation modes 000-010 add into data register; 100-110 add into effective address.
// - Negative flag follows the sign bit of the sized result.
// - Zero flag is set when the sized result is zero.
// - Overflow flag is set on signed overflow at the operation width.
// - Carry flag is set when a carry leaves the top bit of the width.
// - Extend flag takes the same value as the carry flag.
// - Register field picks one of eight data registers as register operand.
// - Any source mode is legal; address register direct only at word or long.
// - Modes 000-110 use the register field; mode 111 subdecodes by register value.
// - Effective address destination must be an alterable memory mode.
// - Address register add works on and writes the whole 32-bit register.
// - Address register add leaves every condition flag unchanged.
// - Address add mode 011 is word with sign extension, 111 is long.
// - Address add register field picks one of eight address registers, always destination.
// - Address add accepts every source mode, including address register and immediate.
// - Immediate add adds an operand of the operation width to the destination.
// - Immediate add size field: 00 byte, 01 word, 10 long.
// - Immediate add destination must be data alterable.
// - Byte takes low byte of extension word; word one word; long two words.
package iau_pkg;

    //------------------------------------------------------------------
    // Instruction fields
    //------------------------------------------------------------------
    localparam int OP_GRP_LSB    = 12;
    localparam int OP_REG_LSB    = 9;
    localparam int OP_MODE_LSB   = 6;
    localparam int EA_MODE_LSB   = 3;
    localparam int EA_REG_LSB    = 0;
    localparam int OP_DIR_BIT    = 8;
    localparam logic [3:0] GRP_ADD     = 4'hD;
    localparam logic [7:0] IMM_ADD_HI  = 8'h06;
    localparam logic [2:0] OPM_ADDR_WORD = 3'h3;
    localparam logic [2:0] OPM_ADDR_LONG = 3'h7;

    localparam logic [2:0] EAM_DREG  = 3'h0;
    localparam logic [2:0] EAM_AREG  = 3'h1;
    localparam logic [2:0] EAM_IND   = 3'h2;
    localparam logic [2:0] EAM_IDX   = 3'h6;
    localparam logic [2:0] EAM_EXT   = 3'h7;
    localparam logic [2:0] EXT_ABS_W = 3'h0;
    localparam logic [2:0] EXT_ABS_L = 3'h1;
    localparam logic [2:0] EXT_PCD   = 3'h2;
    localparam logic [2:0] EXT_PCX   = 3'h3;
    localparam logic [2:0] EXT_IMM   = 3'h4;

    //------------------------------------------------------------------
    // Condition code bits and register bus map
    //------------------------------------------------------------------
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;
    localparam int CC_X = 4;
    localparam logic [4:0]  CCR_RST     = 5'h00;
    localparam logic [31:0] REG_RST     = 32'h00000000;
    localparam logic [4:0]  IDX_CCR     = 5'h10;
    localparam logic [4:0]  IDX_STATUS  = 5'h11;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } iau_size_type;

    typedef enum logic [1:0] {
        KIND_DATA_DST = 2'b00,
        KIND_EA_DST   = 2'b01,
        KIND_ADDR     = 2'b10,
        KIND_IMM      = 2'b11
    } iau_kind_type;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_REG_RD  = 3'b001,
        ST_REG_CAP = 3'b010,
        ST_EXT     = 3'b011,
        ST_EA_RD   = 3'b100,
        ST_EA_CAP  = 3'b101,
        ST_MEM_RD  = 3'b110,
        ST_EXEC    = 3'b111
    } iau_state_type;

endpackage

//--- iau_regfile.sv
// Sixteen-word register file: eight data and eight address registers.
`timescale 1ns/1ps
module iau_regfile (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_we,
    input  wire logic [3:0]  i_waddr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_raddr_a,
    input  wire logic [3:0]  i_raddr_b,
    output logic      [31:0] o_rdata_a,
    output logic      [31:0] o_rdata_b
);
    import iau_pkg::*;

    logic [31:0] mem [16];

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 16; i++) begin
                mem[i] <= REG_RST;
            end
        end else if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Both read ports are registered, so data stand one cycle after the address.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata_a <= REG_RST;
            o_rdata_b <= REG_RST;
        end else begin
            o_rdata_a <= mem[i_raddr_a];
            o_rdata_b <= mem[i_raddr_b];
        end
    end
endmodule

//--- iau_adder.sv
// Sized binary adder with negative, zero, overflow and carry results.
`timescale 1ns/1ps
module iau_adder (
    input  wire logic [31:0]  i_a,
    input  wire logic [31:0]  i_b,
    input  iau_pkg::iau_size_type i_size,
    output logic      [31:0]  o_sum,
    output logic              o_n,
    output logic              o_z,
    output logic              o_v,
    output logic              o_c
);
    import iau_pkg::*;

    logic [8:0]  s8;
    logic [16:0] s16;
    logic [32:0] s32;

    assign s8  = {1'b0, i_a[7:0]} + {1'b0, i_b[7:0]};
    assign s16 = {1'b0, i_a[15:0]} + {1'b0, i_b[15:0]};
    assign s32 = {1'b0, i_a} + {1'b0, i_b};

    always_comb begin
        o_sum = s32[31:0];
        unique case (i_size)
            SZ_BYTE: begin
                o_n = s8[7];
                o_z = (s8[7:0] == 8'h00);
                o_v = (i_a[7] == i_b[7]) && (s8[7] != i_a[7]);
                o_c = s8[8];
            end
            SZ_WORD: begin
                o_n = s16[15];
                o_z = (s16[15:0] == 16'h0000);
                o_v = (i_a[15] == i_b[15]) && (s16[15] != i_a[15]);
                o_c = s16[16];
            end
            default: begin
                o_n = s32[31];
                o_z = (s32[31:0] == 32'h00000000);
                o_v = (i_a[31] == i_b[31]) && (s32[31] != i_a[31]);
                o_c = s32[32];
            end
        endcase
    end
endmodule

//--- iau_unit.sv
// Top of the integer add instruction unit: decode, sequencing and register bus.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module iau_unit (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [15:0] i_opcode,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_illegal,
    output logic             o_ext_req,
    input  wire logic        i_ext_valid,
    input  wire logic [15:0] i_ext_word,
    output logic             o_mem_rd,
    output logic             o_mem_wr,
    output logic [1:0]       o_mem_size,
    output logic [31:0]      o_mem_wdata,
    input  wire logic        i_mem_ack,
    input  wire logic [31:0] i_mem_rdata,
    output logic [4:0]       o_ccr,
    input  wire logic [4:0]  i_bus_addr,
    input  wire logic [31:0] i_bus_wdata,
    input  wire logic        i_bus_wr,
    input  wire logic        i_bus_rd,
    output logic [31:0]      o_bus_rdata
);
    import iau_pkg::*;

    //------------------------------------------------------------------
    // Decode functions
    //------------------------------------------------------------------
    function automatic logic ext_ok(input logic [2:0] reg_v);
        return reg_v <= EXT_IMM;
    endfunction

    function automatic logic mem_alterable(input logic [2:0] mode_v,
                                           input logic [2:0] reg_v);
        if (mode_v == EAM_EXT) begin
            return (reg_v == EXT_ABS_W) || (reg_v == EXT_ABS_L);
        end
        return (mode_v >= EAM_IND) && (mode_v <= EAM_IDX);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] base,
                                          input logic [31:0] val,
                                          input iau_size_type sz);
        unique case (sz)
            SZ_BYTE: return {base[31:8], val[7:0]};
            SZ_WORD: return {base[31:16], val[15:0]};
            default: return val;
        endcase
    endfunction

    function automatic logic [31:0] size_cut(input logic [31:0] val,
                                             input iau_size_type sz);
        return merge(REG_RST, val, sz);
    endfunction

    //------------------------------------------------------------------
    // Combinational decode of a fresh opcode
    //------------------------------------------------------------------
    logic [2:0]   dec_opm;
    logic [2:0]   dec_mode;
    logic [2:0]   dec_ereg;
    iau_kind_type dec_kind;
    iau_size_type dec_size;
    logic         dec_legal;

    assign dec_opm  = i_opcode[OP_MODE_LSB +: 3];
    assign dec_mode = i_opcode[EA_MODE_LSB +: 3];
    assign dec_ereg = i_opcode[EA_REG_LSB +: 3];

    always_comb begin
        dec_kind  = KIND_DATA_DST;
        dec_size  = SZ_LONG;
        dec_legal = 1'b0;
        if (i_opcode[OP_GRP_LSB +: 4] == GRP_ADD) begin
            if ((dec_opm == OPM_ADDR_WORD) || (dec_opm == OPM_ADDR_LONG)) begin
                dec_kind  = KIND_ADDR;
                dec_size  = (dec_opm == OPM_ADDR_WORD) ? SZ_WORD : SZ_LONG;
                dec_legal = (dec_mode != EAM_EXT) || ext_ok(dec_ereg);
            end else begin
                dec_size = iau_size_type'(dec_opm[1:0]);
                if (!dec_opm[OP_DIR_BIT - OP_MODE_LSB]) begin
                    dec_kind  = KIND_DATA_DST;
                    dec_legal = ((dec_mode != EAM_EXT) || ext_ok(dec_ereg))
                              && !((dec_mode == EAM_AREG) && (dec_size == SZ_BYTE));
                end else begin
                    dec_kind  = KIND_EA_DST;
                    dec_legal = mem_alterable(dec_mode, dec_ereg);
                end
            end
        end else if (i_opcode[15:8] == IMM_ADD_HI) begin
            dec_kind  = KIND_IMM;
            dec_size  = iau_size_type'(i_opcode[7:6]);
            dec_legal = (i_opcode[7:6] != 2'b11)
                      && ((dec_mode == EAM_DREG) || mem_alterable(dec_mode, dec_ereg));
        end
    end

    //------------------------------------------------------------------
    // Latched instruction and operands
    //------------------------------------------------------------------
    iau_state_type state;
    iau_state_type next_state;
    iau_kind_type  kind;
    iau_size_type  size;
    logic [2:0]    opreg;
    logic [2:0]    mode;
    logic [2:0]    ereg;
    logic [31:0]   reg_opnd;
    logic [31:0]   ea_opnd;
    logic [31:0]   imm_opnd;
    logic [15:0]   ext_hi;
    logic          ext_second;
    logic          imm_taken;
    logic [31:0]   ext_value;
    logic          ext_last;
    logic [31:0]   rf_a;
    logic [31:0]   rf_b;
    logic [3:0]    rf_raddr;
    logic          rf_we;
    logic [3:0]    rf_waddr;
    logic [31:0]   rf_wdata;
    logic [31:0]   add_a;
    logic [31:0]   add_b;
    iau_size_type  add_size;
    logic [31:0]   add_sum;
    logic          f_n;
    logic          f_z;
    logic          f_v;
    logic          f_c;
    logic          dst_is_reg;
    logic [3:0]    dst_idx;
    logic          idle_wr;

    // Long immediates take two extension words, high word first.
    assign ext_last  = (size != SZ_LONG) || ext_second;
    always_comb begin
        unique case (size)
            SZ_BYTE: ext_value = {24'h000000, i_ext_word[7:0]};
            SZ_WORD: ext_value = {16'h0000, i_ext_word};
            default: ext_value = {ext_hi, i_ext_word};
        endcase
    end

    // Register-destination cases: data register, address register, or immediate into Dn.
    assign dst_is_reg = (kind != KIND_EA_DST) && !((kind == KIND_IMM) && (mode != EAM_DREG));
    assign dst_idx    = (kind == KIND_ADDR) ? {1'b1, opreg} :
                        (kind == KIND_IMM)  ? {1'b0, ereg} : {1'b0, opreg};

    //------------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------------
    function automatic iau_state_type ea_stage(input logic [2:0] mode_v,
                                               input logic [2:0] reg_v);
        if ((mode_v == EAM_DREG) || (mode_v == EAM_AREG)) begin
            return ST_EA_RD;
        end
        if ((mode_v == EAM_EXT) && (reg_v == EXT_IMM)) begin
            return ST_EXT;
        end
        return ST_MEM_RD;
    endfunction

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (i_start && dec_legal) begin
                    next_state = (dec_kind == KIND_IMM) ? ST_EXT : ST_REG_RD;
                end
            end
            ST_REG_RD:  next_state = ST_REG_CAP;
            ST_REG_CAP: next_state = ea_stage(mode, ereg);
            ST_EXT: begin
                if (i_ext_valid && ext_last) begin
                    next_state = ((kind == KIND_IMM) && !imm_taken) ? ea_stage(mode, ereg)
                                                                     : ST_EXEC;
                end
            end
            ST_EA_RD:  next_state = ST_EA_CAP;
            ST_EA_CAP: next_state = ST_EXEC;
            ST_MEM_RD: next_state = i_mem_ack ? ST_EXEC : ST_MEM_RD;
            ST_EXEC: begin
                if (o_mem_wr) begin
                    next_state = i_mem_ack ? ST_IDLE : ST_EXEC;
                end else if (dst_is_reg) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            kind  <= KIND_DATA_DST;
            size  <= SZ_LONG;
            opreg <= 3'h0;
            mode  <= 3'h0;
            ereg  <= 3'h0;
        end else if ((state == ST_IDLE) && i_start && dec_legal) begin
            kind  <= dec_kind;
            size  <= dec_size;
            opreg <= i_opcode[OP_REG_LSB +: 3];
            mode  <= dec_mode;
            ereg  <= dec_ereg;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_hi     <= 16'h0000;
            ext_second <= 1'b0;
            imm_taken  <= 1'b0;
            imm_opnd   <= REG_RST;
        end else if (state == ST_IDLE) begin
            ext_second <= 1'b0;
            imm_taken  <= 1'b0;
        end else if ((state == ST_EXT) && i_ext_valid) begin
            ext_hi     <= i_ext_word;
            ext_second <= !ext_last;
            if (ext_last && (kind == KIND_IMM) && !imm_taken) begin
                imm_opnd  <= ext_value;
                imm_taken <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            reg_opnd <= REG_RST;
            ea_opnd  <= REG_RST;
        end else begin
            if (state == ST_REG_CAP) begin
                reg_opnd <= rf_a;
            end
            if (state == ST_EA_CAP) begin
                ea_opnd <= rf_a;
            end else if ((state == ST_MEM_RD) && i_mem_ack) begin
                ea_opnd <= size_cut(i_mem_rdata, size);
            end else if ((state == ST_EXT) && i_ext_valid && ext_last
                         && !((kind == KIND_IMM) && !imm_taken)) begin
                ea_opnd <= ext_value;
            end
        end
    end

    //------------------------------------------------------------------
    // Execution
    //------------------------------------------------------------------
    always_comb begin
        add_size = size;
        unique case (kind)
            KIND_DATA_DST: begin
                add_a = reg_opnd;
                add_b = ea_opnd;
            end
            KIND_EA_DST: begin
                add_a = ea_opnd;
                add_b = reg_opnd;
            end
            KIND_ADDR: begin
                add_a    = reg_opnd;
                add_b    = (size == SZ_WORD) ? {{16{ea_opnd[15]}}, ea_opnd[15:0]}
                                             : ea_opnd;
                add_size = SZ_LONG;
            end
            default: begin
                add_a = ea_opnd;
                add_b = imm_opnd;
            end
        endcase
    end

    iau_adder u_adder (
        .i_a    (add_a),
        .i_b    (add_b),
        .i_size (add_size),
        .o_sum  (add_sum),
        .o_n    (f_n),
        .o_z    (f_z),
        .o_v    (f_v),
        .o_c    (f_c)
    );

    function automatic logic [3:0] dst_idx_rd(input iau_kind_type k, input logic [2:0] r);
        return {k == KIND_ADDR, r};
    endfunction

    // Bus writes to registers are refused while an instruction runs, to keep operands stable.
    assign idle_wr  = i_bus_wr && (state == ST_IDLE);
    assign rf_we    = ((state == ST_EXEC) && dst_is_reg) || (idle_wr && !i_bus_addr[4]);
    assign rf_waddr = (state == ST_EXEC) ? dst_idx : i_bus_addr[3:0];
    assign rf_wdata = (state != ST_EXEC) ? i_bus_wdata :
                      (kind == KIND_ADDR) ? add_sum : merge(add_a, add_sum, size);
    assign rf_raddr = (state == ST_REG_RD) ? dst_idx_rd(kind, opreg)
                                           : {mode == EAM_AREG, ereg};

    iau_regfile u_regfile (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_we       (rf_we),
        .i_waddr    (rf_waddr),
        .i_wdata    (rf_wdata),
        .i_raddr_a  (rf_raddr),
        .i_raddr_b  (i_bus_addr[3:0]),
        .o_rdata_a  (rf_a),
        .o_rdata_b  (rf_b)
    );

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ccr <= CCR_RST;
        end else if ((state == ST_EXEC) && (next_state == ST_IDLE || !dst_is_reg)
                     && !o_mem_wr && (kind != KIND_ADDR)) begin
            o_ccr[CC_N] <= f_n;
            o_ccr[CC_Z] <= f_z;
            o_ccr[CC_V] <= f_v;
            o_ccr[CC_C] <= f_c;
            o_ccr[CC_X] <= f_c;
        end else if (idle_wr && (i_bus_addr == IDX_CCR)) begin
            o_ccr <= i_bus_wdata[4:0];
        end
    end

    //------------------------------------------------------------------
    // Handshake outputs
    //------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_busy      <= 1'b0;
            o_done      <= 1'b0;
            o_illegal   <= 1'b0;
            o_ext_req   <= 1'b0;
            o_mem_rd    <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_size  <= SZ_LONG;
            o_mem_wdata <= REG_RST;
        end else begin
            o_busy    <= next_state != ST_IDLE;
            o_done    <= (state != ST_IDLE) && (next_state == ST_IDLE);
            o_illegal <= (state == ST_IDLE) && i_start && !dec_legal;
            o_ext_req <= (next_state == ST_EXT) && !((state == ST_EXT) && i_ext_valid
                                                     && ext_last && next_state != ST_EXT);
            o_mem_rd  <= next_state == ST_MEM_RD;
            if ((state == ST_EXEC) && !dst_is_reg && !o_mem_wr) begin
                o_mem_wr    <= 1'b1;
                o_mem_wdata <= size_cut(add_sum, size);
            end else if (i_mem_ack) begin
                o_mem_wr <= 1'b0;
            end
            if ((state == ST_IDLE) && i_start) begin
                o_mem_size <= dec_size;
            end
        end
    end

    //------------------------------------------------------------------
    // Register bus read path
    //------------------------------------------------------------------
    logic        rd_from_rf;
    logic [31:0] rd_local;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_from_rf <= 1'b0;
            rd_local   <= REG_RST;
        end else begin
            rd_from_rf <= i_bus_rd && !i_bus_addr[4];
            if (i_bus_rd && (i_bus_addr == IDX_CCR)) begin
                rd_local <= {27'h0000000, o_ccr};
            end else if (i_bus_rd && (i_bus_addr == IDX_STATUS)) begin
                rd_local <= {31'h00000000, state != ST_IDLE};
            end else begin
                rd_local <= REG_RST;
            end
        end
    end

    // The register file read port is already registered, so only a select mux follows it.
    assign o_bus_rdata = rd_from_rf ? rf_b : rd_local;
endmodule

//--- iau_unit_asserts.sv
// Port checker of the add unit, bound to its top module.
`timescale 1ns/1ps
module iau_unit_chk (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_start,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        o_illegal,
    input wire logic        o_ext_req,
    input wire logic        i_ext_valid,
    input wire logic        o_mem_rd,
    input wire logic        o_mem_wr,
    input wire logic        i_mem_ack,
    input wire logic        i_bus_wr,
    input wire logic [1:0]  o_mem_size,
    input wire logic [31:0] o_mem_wdata,
    input wire logic [4:0]  o_ccr,
    input wire logic [4:0]  i_bus_addr
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    AST_DONE_PULSE: assert property (o_done |=> !o_done)
        else $error("done pulse too long");
    AST_START_ANSWER: assert property (i_start && !o_busy |=> o_busy || o_illegal)
        else $error("start neither taken nor refused");
    AST_DONE_BOUND: assert property (i_start && !o_busy |-> ##[1:60] (o_done || o_illegal))
        else $error("instruction never finished");
    AST_ILLEGAL_IDLE: assert property (o_illegal |-> !o_busy && !o_done)
        else $error("illegal opcode started work");
    AST_CCR_CAUSE: assert property ($changed(o_ccr) |->
        o_busy || o_done || $past(i_bus_wr && i_bus_addr == 5'h10))
        else $error("flags changed without cause");
    AST_X_EQ_C: assert property ($changed(o_ccr) && !$past(i_bus_wr) |-> o_ccr[4] == o_ccr[0])
        else $error("extend differs from carry");
    AST_WR_HOLD: assert property (o_mem_wr && !i_mem_ack |=> o_mem_wr && $stable(o_mem_wdata))
        else $error("write dropped before ack");
    AST_EXT_HOLD: assert property (o_ext_req && !i_ext_valid |=> o_ext_req)
        else $error("extension request dropped");
    AST_WDATA_SIZE: assert property (o_mem_wr |-> (o_mem_size == 2'h2) ||
        (o_mem_size == 2'h1 && o_mem_wdata[31:16] == 16'h0) ||
        (o_mem_size == 2'h0 && o_mem_wdata[31:8] == 24'h0))
        else $error("write data wider than size");
    AST_IDLE_QUIET: assert property (!o_busy |-> !o_mem_rd && !o_mem_wr && !o_ext_req)
        else $error("operand traffic while idle");
endmodule
bind iau_unit iau_unit_chk CHK (.*);

//--- iau_unit_bench.sv
// Self-checking bench of the integer add instruction unit.
`timescale 1ns/1ps
module iau_unit_bench;
    import iau_pkg::*;
    logic i_core_clk = 0, i_rst = 1, i_start = 0, i_ext_valid = 0, i_mem_ack = 0;
    logic i_bus_wr = 0, i_bus_rd = 0, rd_d = 0, o_busy, o_done, o_illegal;
    logic o_ext_req, o_mem_rd, o_mem_wr;
    logic [1:0] o_mem_size;
    logic [4:0] i_bus_addr = 0, o_ccr, cc;
    logic [15:0] i_opcode = 0, i_ext_word = 0;
    logic [15:0] ill [4] = '{16'h06C3, 16'h0608, 16'hD608, 16'hD7BC};
    logic [31:0] i_mem_rdata = 0, i_bus_wdata = 0, o_mem_wdata, o_bus_rdata;
    logic [31:0] a, b, m, r, dv, lf = 32'hC9452A89;
    logic [31:0] exq [$];
    int fail_count = 0, tests_run = 0, k;
    iau_unit DUT (.*);
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    // Sized sum and flags; a long add needs the 33rd bit for carry.
    function automatic void ref_add(input logic [31:0] x, y, input int z);
        logic [32:0] t;
        logic [31:0] tb;
        m = z == 0 ? 32'hFF : z == 1 ? 32'hFFFF : 32'hFFFFFFFF;
        tb = m ^ (m >> 1);
        t = {1'b0, x & m} + {1'b0, y & m};
        r = t[31:0] & m;
        cc = {t > {1'b0, m}, |(r & tb), r == 0, |((x ^ r) & (y ^ r) & tb), t > {1'b0, m}};
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] v);
        logic [31:0] e;
        e = exq.pop_front();
        tests_run++;
        if (v !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, v, e);
        end
    endtask
    task automatic wr(input logic [4:0] ad, input logic [31:0] d);
        @(posedge i_core_clk);
        i_bus_wr <= 1;
        i_bus_addr <= ad;
        i_bus_wdata <= d;
        @(posedge i_core_clk);
        i_bus_wr <= 0;
    endtask
    task automatic rd(input logic [4:0] ad, input logic [31:0] e);
        exq.push_back(e);
        @(posedge i_core_clk);
        i_bus_rd <= 1;
        i_bus_addr <= ad;
        @(posedge i_core_clk);
        i_bus_rd <= 0;
    endtask
    // Expectation 1 is a done pulse, 2 an illegal pulse.
    task automatic go(input logic [15:0] op, input logic [31:0] e);
        int n;
        exq.push_back(e);
        @(posedge i_core_clk);
        i_start <= 1;
        i_opcode <= op;
        @(posedge i_core_clk);
        i_start <= 0;
        for (n = 0; n < 60; n++) begin
            @(negedge i_core_clk);
            if (o_done || o_illegal) break;
        end
        if (n == 60) begin
            fail_count++;
            results();
        end
        @(posedge i_core_clk);
    endtask
    always @(posedge i_core_clk) begin
        rd_d <= i_bus_rd;
        i_ext_valid <= o_ext_req && !i_ext_valid;
        i_mem_ack <= (o_mem_rd || o_mem_wr) && !i_mem_ack;
        i_mem_rdata <= dv;
    end
    always @(negedge i_core_clk) begin
        if (rd_d) chk(o_bus_rdata);
        if ((o_done | o_illegal) !== 1'b0) chk({30'h0, o_illegal, o_done});
        if (o_mem_wr && i_mem_ack) chk(o_mem_wdata);
    end
    initial begin
        forever #50 i_core_clk = ~i_core_clk;
    end
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst <= 0;
        rd(5'h10, 0);
        rd(5'h03, 0);
        rd(5'h15, 0);
        for (k = 0; k < 3; k++) begin
            a = rnd();
            b = rnd();
            wr(5'h03, a);
            wr(5'h05, b);
            ref_add(b, a, k);
            go(16'hD605 | 16'(k << 6), 1);
            rd(5'h03, (a & ~m) | r);
            rd(5'h10, {27'h0, cc});
            wr(5'h03, a);
            i_ext_word <= b[15:0];
            ref_add({b[15:0], b[15:0]}, a, k);
            go(16'h0603 | 16'(k << 6), 1);
            rd(5'h03, (a & ~m) | r);
            rd(5'h10, {27'h0, cc});
        end
        for (k = 0; k < 2; k++) begin
            b = rnd() | 32'h00008000;
            wr(5'h05, b);
            wr(5'h10, 32'h0A);
            wr(5'h0A, a);
            go(16'hD4C5 | 16'(k << 8), 1);
            rd(5'h0A, a + (k ? b : {{16{b[15]}}, b[15:0]}));
            rd(5'h10, 32'h0A);
        end
        dv = rnd();
        wr(5'h03, a);
        ref_add(a, dv, 2);
        exq.push_back(r);
        go(16'hD790, 1);
        rd(5'h10, {27'h0, cc});
        i_ext_word <= dv[15:0];
        ref_add(a, {dv[15:0], dv[15:0]}, 2);
        go(16'hD6BC, 1);
        rd(5'h03, r);
        foreach (ill[i]) go(ill[i], 2);
        rd(5'h11, 0);
        // Let the last read data be compared before the verdict; leftovers are mismatches.
        @(posedge i_core_clk);
        if (exq.size() != 0) fail_count++;
        results();
    end
endmodule
